// ---- hw/lft_regs.sv ----
// Serial-port register group for LED levels, flash timeout and flags
`timescale 1ns/1ps
module lft_regs import lft_pkg::*; #(
  parameter int P_STEP_CYCLES = LFT_STEP_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_n,
  input wire logic i_flash_on,
  output logic [2:0] o_torch_led1_code,
  output logic [2:0] o_torch_led2_code,
  output logic [3:0] o_flash_led1_code,
  output logic [3:0] o_flash_led2_code,
  output logic [1:0] o_switch_limit_code,
  output logic o_flash_end,
  output logic o_flag_timeout
);
  // ----------------------------------------------------------------
  // Address decode, shared by write and read paths
  // ----------------------------------------------------------------
  function automatic logic [1:0] lft_sel(input logic [7:0] a);
    case (a)
      LFT_OFS_TORCH: lft_sel = 2'h1;
      LFT_OFS_FLASH: lft_sel = 2'h2;
      LFT_OFS_DUR: lft_sel = 2'h3;
      default: lft_sel = 2'h0;
    endcase
  endfunction

  logic [2:0] scl_s_q;
  logic [2:0] sda_s_q;
  logic scl_f_q;
  logic sda_f_q;
  logic scl_p_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  lft_state_t state_q;
  lft_state_t nxt_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic drv_q;
  logic wr_q;
  logic [7:0] wdat_q;
  logic [7:0] torch_q;
  logic [7:0] flash_q;
  logic [7:0] dur_q;
  logic load_rd;
  logic [7:0] rd_mux;
  logic expire;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Level only moves when stages 2 and 3 agree, which rejects single glitches
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[1:0], i_scl};
      sda_s_q <= {sda_s_q[1:0], i_sda};
      if (scl_s_q[1] == scl_s_q[2]) begin
        scl_f_q <= scl_s_q[2];
      end
      if (sda_s_q[1] == sda_s_q[2]) begin
        sda_f_q <= sda_s_q[2];
      end
      scl_p_q <= scl_f_q;
      sda_p_q <= sda_f_q;
    end
  end

  // Bus events
  assign scl_rise = scl_f_q && !scl_p_q;
  assign scl_fall = !scl_f_q && scl_p_q;
  assign start_c = scl_f_q && scl_p_q && sda_p_q && !sda_f_q;
  assign stop_c = scl_f_q && scl_p_q && !sda_p_q && sda_f_q;
  assign load_rd = (state_q == LFT_ST_ACK) && scl_fall && (nxt_q == LFT_ST_RDAT);

  // Read data; reserved bits already zero in storage
  always_comb begin
    case (lft_sel(ptr_q))
      2'h1: rd_mux = torch_q;
      2'h2: rd_mux = flash_q;
      2'h3: rd_mux = dur_q;
      default: rd_mux = (ptr_q == LFT_OFS_FLAGS) ? {7'h00, o_flag_timeout} : 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Serial protocol engine
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= LFT_ST_IDLE;
      nxt_q <= LFT_ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      drv_q <= 1'b0;
      wr_q <= 1'b0;
      wdat_q <= 8'h00;
    end else begin
      wr_q <= 1'b0;
      if (start_c) begin
        state_q <= LFT_ST_DEV;
        bit_q <= 4'h0;
        drv_q <= 1'b0;
      end else if (stop_c) begin
        state_q <= LFT_ST_IDLE;
        drv_q <= 1'b0;
      end else begin
        case (state_q)
          LFT_ST_DEV, LFT_ST_PTR, LFT_ST_WDAT: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_f_q};
              bit_q <= bit_q + 4'h1;
            end else if (scl_fall && bit_q == 4'h8) begin
              bit_q <= 4'h0;
              drv_q <= 1'b1; // Acknowledge each byte
              state_q <= LFT_ST_ACK;
              if (state_q == LFT_ST_DEV) begin
                if (sh_q[7:1] != LFT_DEV_ADDR) begin
                  drv_q <= 1'b0; // Not addressed: stay silent
                  state_q <= LFT_ST_IDLE;
                end
                nxt_q <= sh_q[0] ? LFT_ST_RDAT : LFT_ST_PTR;
              end else if (state_q == LFT_ST_PTR) begin
                ptr_q <= sh_q;
                nxt_q <= LFT_ST_WDAT;
              end else begin
                wr_q <= 1'b1;
                wdat_q <= sh_q;
                nxt_q <= LFT_ST_WDAT;
              end
            end
          end
          LFT_ST_ACK: begin
            if (scl_fall) begin
              state_q <= nxt_q;
              if (load_rd) begin
                tx_q <= {rd_mux[6:0], 1'b0};
                drv_q <= ~rd_mux[7];
                bit_q <= 4'h1;
              end else begin
                drv_q <= 1'b0;
              end
            end
          end
          LFT_ST_RDAT: begin
            if (scl_fall) begin
              if (bit_q == 4'h8) begin
                drv_q <= 1'b0; // Release for host acknowledge
                state_q <= LFT_ST_RACK;
              end else begin
                drv_q <= ~tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
                bit_q <= bit_q + 4'h1;
              end
            end
          end
          LFT_ST_RACK: begin
            if (scl_rise) begin
              state_q <= sda_f_q ? LFT_ST_IDLE : LFT_ST_ACK;
              nxt_q <= LFT_ST_RDAT;
            end
          end
          default: state_q <= LFT_ST_IDLE;
        endcase
      end
    end
  end

  // Open-drain data pin: only ever pulls low
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sda <= 1'b0;
      o_sda_oe_n <= 1'b1;
    end else begin
      o_sda <= 1'b0;
      o_sda_oe_n <= ~drv_q;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      torch_q <= LFT_RST_TORCH & LFT_MASK_TORCH;
      flash_q <= LFT_RST_FLASH;
      dur_q <= LFT_RST_DUR & LFT_MASK_DUR;
    end else if (wr_q) begin
      case (lft_sel(ptr_q))
        2'h1: torch_q <= wdat_q & LFT_MASK_TORCH;
        2'h2: flash_q <= wdat_q;
        2'h3: dur_q <= wdat_q & LFT_MASK_DUR;
        default: torch_q <= torch_q;
      endcase
    end
  end

  // Level codes go straight from storage to the current sources
  assign o_torch_led1_code = torch_q[LFT_TORCH1_LSB +: 3];
  assign o_torch_led2_code = torch_q[LFT_TORCH2_LSB +: 3];
  assign o_flash_led1_code = flash_q[LFT_FLASH1_LSB +: 4];
  assign o_flash_led2_code = flash_q[LFT_FLASH2_LSB +: 4];
  assign o_switch_limit_code = dur_q[LFT_LIM_LSB +: 2];

  // ----------------------------------------------------------------
  // Flash timeout and flag
  // ----------------------------------------------------------------
  lft_timer #(
    .P_STEP_CYCLES(P_STEP_CYCLES)
  ) u_timer (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_flash_on(i_flash_on),
    .i_code(dur_q[LFT_TMO_LSB +: 5]),
    .o_expire(expire)
  );

  assign o_flash_end = expire;

  // Set beats clear so an expiry during the read is not lost
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_flag_timeout <= 1'b0;
    end else if (expire) begin
      o_flag_timeout <= 1'b1;
    end else if (load_rd && ptr_q == LFT_OFS_FLAGS) begin
      o_flag_timeout <= 1'b0;
    end
  end
endmodule

// ---- hw/lft_timer.sv ----
// Flash timeout timer with 32 ms step divider
`timescale 1ns/1ps
module lft_timer import lft_pkg::*; #(
  parameter int P_STEP_CYCLES = LFT_STEP_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_flash_on,
  input wire logic [4:0] i_code,
  output logic o_expire
);
  localparam int W = $clog2(P_STEP_CYCLES);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  generate
    if (P_STEP_CYCLES < 2) begin : g_bad
      $error("P_STEP_CYCLES must be at least 2");
    end
  endgenerate

  logic on_q;
  logic run_q;
  logic [4:0] code_q;
  logic [4:0] step_q;
  logic [W-1:0] cyc_q;
  logic tick;

  // One-cycle enable at the end of each 32 ms step
  assign tick = run_q && (cyc_q == W'(P_STEP_CYCLES - 1));

  // ----------------------------------------------------------------
  // Step counting
  // ----------------------------------------------------------------
  // Code is captured at turn-on so a rewrite mid-flash has no effect
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      on_q <= 1'b0;
      run_q <= 1'b0;
      code_q <= 5'h00;
      step_q <= 5'h00;
      cyc_q <= '0;
      o_expire <= 1'b0;
    end else begin
      on_q <= i_flash_on;
      o_expire <= 1'b0;
      if (i_flash_on && !on_q) begin
        run_q <= 1'b1;
        code_q <= i_code;
        step_q <= 5'h00;
        cyc_q <= '0;
      end else if (!i_flash_on) begin
        run_q <= 1'b0; // Flash ended early, no expiry
      end else if (tick) begin
        cyc_q <= '0;
        if (step_q == code_q) begin
          run_q <= 1'b0; // (code + 1) steps done
          o_expire <= 1'b1;
        end else begin
          step_q <= step_q + 5'h01;
        end
      end else if (run_q) begin
        cyc_q <= cyc_q + W'(1);
      end
    end
  end
endmodule

// ---- shared/lft_pkg.sv ----
// Constants for the LED level and flash timeout register group
package lft_pkg;
  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  localparam logic [6:0] LFT_DEV_ADDR = 7'h53;
  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] LFT_OFS_TORCH = 8'hA0;
  localparam logic [7:0] LFT_OFS_FLASH = 8'hB0;
  localparam logic [7:0] LFT_OFS_DUR = 8'hC0;
  localparam logic [7:0] LFT_OFS_FLAGS = 8'hD0;
  localparam logic [7:0] LFT_RST_TORCH = 8'h52;
  localparam logic [7:0] LFT_RST_FLASH = 8'hDD;
  localparam logic [7:0] LFT_RST_DUR = 8'h6F;
  localparam logic [7:0] LFT_MASK_TORCH = 8'h3F;
  localparam logic [7:0] LFT_MASK_DUR = 8'h7F;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LFT_TORCH1_LSB = 0;
  localparam int LFT_TORCH2_LSB = 3;
  localparam int LFT_FLASH1_LSB = 0;
  localparam int LFT_FLASH2_LSB = 4;
  localparam int LFT_TMO_LSB = 0;
  localparam int LFT_LIM_LSB = 5;
  localparam int LFT_FLAG_TMO_BIT = 0;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int LFT_CLK_HZ = 200_000_000;
  localparam int LFT_STEP_MS = 32;
  localparam int LFT_STEP_CYCLES = LFT_STEP_MS * (LFT_CLK_HZ / 1000);
  // ----------------------------------------------------------------
  // Serial state machine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LFT_ST_IDLE = 3'b000,
    LFT_ST_DEV = 3'b001,
    LFT_ST_PTR = 3'b010,
    LFT_ST_WDAT = 3'b011,
    LFT_ST_ACK = 3'b100,
    LFT_ST_RDAT = 3'b101,
    LFT_ST_RACK = 3'b110
  } lft_state_t;
endpackage

// ---- sim/lft_host.sv ----
// Serial host model that writes and reads the register group
`timescale 1ns/1ps
module lft_host import lft_pkg::*; (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  // Idle bus: both lines released high
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // Eight cycles per phase leaves room for the pin synchronisers
  task automatic hp();
    repeat (8) @(negedge i_clk);
  endtask
  task automatic pulse(output logic s);
    hp();
    o_scl = 1'b1;
    hp();
    s = i_sda;
    o_scl = 1'b0;
  endtask
  task automatic start();
    o_sda = 1'b1;
    hp();
    o_scl = 1'b1;
    hp();
    o_sda = 1'b0;
    hp();
    o_scl = 1'b0;
  endtask
  task automatic stop();
    o_sda = 1'b0;
    hp();
    o_scl = 1'b1;
    hp();
    o_sda = 1'b1;
    hp();
  endtask
  // Byte out MSB first, then release the line and sample acknowledge
  task automatic xbyte(input logic [7:0] b, output logic nak);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      o_sda = b[i];
      pulse(s);
    end
    o_sda = 1'b1;
    pulse(nak);
  endtask
  // Address then register then data; a read turns round with a repeated start
  task automatic xfer(input logic rd, input logic [7:0] a, inout logic [7:0] d,
    output logic ok);
    logic k0, k1, k2, s;
    start();
    xbyte({LFT_DEV_ADDR, 1'b0}, k0);
    xbyte(a, k1);
    if (rd) begin
      start();
      xbyte({LFT_DEV_ADDR, 1'b1}, k2);
      o_sda = 1'b1;
      for (int i = 7; i >= 0; i--) pulse(d[i]);
      pulse(s);
    end else xbyte(d, k2);
    stop();
    ok = !(k0 | k1 | k2);
  endtask
endmodule

// ---- sim/lft_regs_chk.sv ----
// Assertion checker for the LED level and flash timeout register group
`timescale 1ns/1ps
module lft_regs_chk import lft_pkg::*; #(
  parameter int P_STEP_CYCLES = LFT_STEP_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda,
  input wire logic o_sda_oe_n,
  input wire logic i_flash_on,
  input wire logic [2:0] o_torch_led1_code,
  input wire logic [2:0] o_torch_led2_code,
  input wire logic [3:0] o_flash_led1_code,
  input wire logic [3:0] o_flash_led2_code,
  input wire logic [1:0] o_switch_limit_code,
  input wire logic o_flash_end,
  input wire logic o_flag_timeout
);
  int on_cnt_q;
  // Flash-on run length; the captured code is hidden, so only a window
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) on_cnt_q <= 0;
    else if (!i_flash_on) on_cnt_q <= 0;
    else on_cnt_q <= on_cnt_q + 1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  torch_reset_a: assert property ($rose(i_rst_n) |-> o_torch_led1_code == 3'h2 &&
    o_torch_led2_code == 3'h2) else $error("torch codes off after reset");
  flash_reset_a: assert property ($rose(i_rst_n) |-> o_flash_led1_code == 4'hD &&
    o_flash_led2_code == 4'hD) else $error("flash codes off after reset");
  limit_reset_a: assert property ($rose(i_rst_n) |-> o_switch_limit_code == 2'h3)
    else $error("limit code off after reset");
  end_pulse_a: assert property (o_flash_end |=> !o_flash_end)
    else $error("flash end longer than one cycle");
  tmo_window_a: assert property (o_flash_end |-> on_cnt_q >= P_STEP_CYCLES - 1 &&
    on_cnt_q <= 32 * P_STEP_CYCLES + 3) else $error("flash end outside timeout window");
  flag_set_a: assert property (o_flash_end |-> ##[0:1] o_flag_timeout)
    else $error("timeout flag not set on expiry");
  flag_cause_a: assert property ($rose(o_flag_timeout) |->
    o_flash_end || $past(o_flash_end)) else $error("timeout flag set without expiry");
  // A clear only comes while the device holds the line for the flags byte
  flag_clear_a: assert property ($fell(o_flag_timeout) |-> !o_sda_oe_n &&
    !$past(o_sda_oe_n)) else $error("timeout flag cleared outside a read");
  // Register outputs may only move shortly after a serial clock fall
  codes_hold_a: assert property (i_scl [*8] |-> $stable({o_torch_led1_code,
    o_torch_led2_code, o_flash_led1_code, o_flash_led2_code, o_switch_limit_code}))
    else $error("codes moved while serial clock idle high");
endmodule
bind lft_regs lft_regs_chk #(.P_STEP_CYCLES(P_STEP_CYCLES)) u_chk (.i_clk, .i_rst_n, .i_scl,
  .i_sda, .o_sda, .o_sda_oe_n, .i_flash_on, .o_torch_led1_code, .o_torch_led2_code,
  .o_flash_led1_code, .o_flash_led2_code, .o_switch_limit_code, .o_flash_end, .o_flag_timeout);

// ---- sim/testbench.sv ----
// Self-checking testbench for the LED level and flash timeout registers
`timescale 1ns/1ps
module testbench import lft_pkg::*;;
  localparam int STEP = 20;
  localparam logic [7:0] ADR [4] = '{LFT_OFS_TORCH, LFT_OFS_FLASH, LFT_OFS_DUR, LFT_OFS_FLAGS};
  localparam int TC [4] = '{0, 1, 6, 31};
  logic i_clk, i_rst_n, i_flash_on, scl, sda_h, sda_w, o_sda, oe_n, fend, flag, ok, fexp;
  logic [2:0] t1, t2;
  logic [3:0] f1, f2;
  logic [1:0] lim;
  logic [7:0] sh_t, sh_f, sh_d, d, v;
  int error_cnt = 0;
  int n_checks = 0;
  int n;
  integer seed = 72;
  // Pulled-up data line, low when either side pulls
  assign sda_w = sda_h & (oe_n | o_sda);
  lft_regs #(.P_STEP_CYCLES(STEP)) DUT (.i_clk, .i_rst_n, .i_scl(scl), .i_sda(sda_w), .o_sda,
    .o_sda_oe_n(oe_n), .i_flash_on, .o_torch_led1_code(t1), .o_torch_led2_code(t2),
    .o_flash_led1_code(f1), .o_flash_led2_code(f2), .o_switch_limit_code(lim),
    .o_flash_end(fend), .o_flag_timeout(flag));
  lft_host u_host (.i_clk, .i_sda(sda_w), .o_scl(scl), .o_sda(sda_h));
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Read-back value from the shadows; unused bits read as zero
  function automatic logic [7:0] rexp(logic [7:0] a);
    case (a)
      LFT_OFS_TORCH: return sh_t & 8'h3F;
      LFT_OFS_FLASH: return sh_f;
      LFT_OFS_DUR: return sh_d & 8'h7F;
      LFT_OFS_FLAGS: return {7'h00, fexp};
      default: return 8'h00;
    endcase
  endfunction
  task automatic wrs(logic [7:0] a, logic [7:0] x);
    logic [7:0] y;
    y = x;
    u_host.xfer(1'b0, a, y, ok);
    chk("write ack", 8'h01, 8'(ok));
    if (a == LFT_OFS_TORCH) sh_t = x;
    if (a == LFT_OFS_FLASH) sh_f = x;
    if (a == LFT_OFS_DUR) sh_d = x;
  endtask
  task automatic rdchk(logic [7:0] a);
    u_host.xfer(1'b1, a, d, ok);
    chk("read ack", 8'h01, 8'(ok));
    chk("read data", rexp(a), d);
  endtask
  task automatic chk_outs();
    chk("torch1", 8'(sh_t[2:0]), 8'(t1));
    chk("torch2", 8'(sh_t[5:3]), 8'(t2));
    chk("flash1", 8'(sh_f[3:0]), 8'(f1));
    chk("flash2", 8'(sh_f[7:4]), 8'(f2));
    chk("limit", 8'(sh_d[6:5]), 8'(lim));
  endtask
  initial begin
    i_rst_n = 1'b0;
    i_flash_on = 1'b0;
    fexp = 1'b0;
    sh_t = 8'h52;
    sh_f = 8'hDD;
    sh_d = 8'h6F;
    repeat (3) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_clk);
    chk_outs();
    foreach (ADR[i]) rdchk(ADR[i]);
    // All-ones and all-zeros first, then random bytes
    for (int i = 0; i < 12; i++) begin
      v = (i < 3) ? 8'hFF : (i < 6) ? 8'h00 : 8'($random(seed));
      wrs(ADR[i % 3], v);
      chk_outs();
      rdchk(ADR[i % 3]);
    end
    // Mid-run reset brings every field back to its default
    i_rst_n = 1'b0;
    repeat (3) @(negedge i_clk);
    i_rst_n = 1'b1;
    sh_t = LFT_RST_TORCH;
    sh_f = LFT_RST_FLASH;
    sh_d = LFT_RST_DUR;
    repeat (4) @(negedge i_clk);
    chk_outs();
    // Foreign device address unanswered; unmapped register dropped
    u_host.start();
    u_host.xbyte(8'h20, ok);
    u_host.stop();
    chk("foreign nack", 8'h01, 8'(ok));
    wrs(8'h55, 8'h3C);
    chk_outs();
    rdchk(8'h55);
    // Two data bytes in one frame: the second rewrites the same register
    v = 8'($random(seed));
    u_host.start();
    u_host.xbyte({LFT_DEV_ADDR, 1'b0}, ok);
    u_host.xbyte(LFT_OFS_FLASH, ok);
    u_host.xbyte(~v, ok);
    u_host.xbyte(v, ok);
    u_host.stop();
    chk("burst ack", 8'h00, 8'(ok));
    sh_f = v;
    chk_outs();
    // Every limit code with a timeout; the last rewrites the code mid-flash
    for (int l = 0; l < 4; l++) begin
      wrs(LFT_OFS_DUR, {1'b0, 2'(l), 5'(TC[l])});
      chk_outs();
      i_flash_on = 1'b1;
      n = 0;
      fork
        if (l == 3) wrs(LFT_OFS_DUR, 8'h00);
        while (fend !== 1'b1 && n < 2000) begin
          @(negedge i_clk);
          n++;
        end
      join
      i_flash_on = 1'b0;
      if (n >= 2000) begin
        error_cnt++;
        close_out();
      end
      chk("timeout", 8'h01, 8'(n >= (TC[l] + 1) * STEP && n <= (TC[l] + 1) * STEP + 3));
      @(negedge i_clk);
      chk("flag out", 8'h01, 8'(flag));
      fexp = 1'b1;
      rdchk(LFT_OFS_FLAGS);
      fexp = 1'b0;
      rdchk(LFT_OFS_FLAGS);
      chk("flag clear", 8'h00, 8'(flag));
    end
    // Flash dropped before expiry leaves no flag
    i_flash_on = 1'b1;
    repeat (STEP / 2) @(negedge i_clk);
    i_flash_on = 1'b0;
    repeat (3 * STEP) @(negedge i_clk);
    chk("cancel flag", 8'h00, 8'(flag));
    close_out();
  end
endmodule
